// *** verilog/uarx_consts.svh ***
`ifndef UARX_CONSTS_SVH
`define UARX_CONSTS_SVH
// Samples per bit
`define UARX_SPB_NORM      5'd16
`define UARX_SPB_DBL       5'd8
// First of the three centre samples, as a sample number
`define UARX_CTR_NORM      5'd8
`define UARX_CTR_DBL       5'd4
// Character size codes (data bits minus five, nine is 4)
`define UARX_CSZ_NINE      3'd4
// Receive buffer depth
`define UARX_BUF_DEPTH     2
// Clock rate and default divider
`define UARX_CLK_HZ        40000000
`define UARX_DIV_DEFAULT   16'h0015
`endif

// *** verilog/uarx_pkg.sv ***
package uarx_pkg;
    // Received character with its status, as it sits in the buffer
    typedef struct packed {
        logic [8:0] data;        // Data bits, ninth bit on top
        logic       stop_err;    // First stop bit read low
        logic       par_err;     // Parity mismatch
    } uarx_char_type;

    // Receiver states, Gray coded along the usual path
    typedef enum logic [2:0] {
        UARX_IDLE  = 3'b000,
        UARX_START = 3'b001,
        UARX_DATA  = 3'b011,
        UARX_PAR   = 3'b010,
        UARX_STOP  = 3'b110
    } uarx_state_type;
endpackage

// *** verilog/uarx_buf.sv ***
`timescale 1ns/100ps
`include "uarx_consts.svh"
// Two-entry buffer with valid/ready on both sides
module uarx_buf #(
    parameter int WIDTH = 11
) (
    input  wire logic             clk,       // System clock
    input  wire logic             resetn,    // Async reset, low
    input  wire logic             flush,     // Empty the buffer
    input  wire logic [WIDTH-1:0] in_data,   // Word to store
    input  wire logic             in_valid,  // Word offered
    output logic                  in_ready,  // Room for a word
    output logic      [WIDTH-1:0] out_data,  // Oldest word
    output logic                  out_valid, // Word waiting
    input  wire logic             out_ready  // Reader takes word
);
    logic [WIDTH-1:0] mem_r [0:1];
    logic             wp_r;
    logic             rp_r;
    logic [1:0]       cnt_r;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    initial begin
        if (WIDTH < 1) $error("uarx_buf: WIDTH must be positive");
    end

    // Honest full and empty from the fill count
    assign in_ready  = (cnt_r != 2'd2);
    assign out_valid = (cnt_r != 2'd0);
    assign out_data  = mem_r[rp_r];

    // Storage is written only on push, so no reset is needed
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    // Pointers and count; flush wins over push and pop
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'd0;
        end else if (flush) begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'd0;
        end else begin
            if (push) wp_r <= ~wp_r;
            if (pop)  rp_r <= ~rp_r;
            if (push && !pop) cnt_r <= cnt_r + 2'd1;
            else if (pop && !push) cnt_r <= cnt_r - 2'd1;
        end
    end
endmodule

// *** verilog/uarx_rx.sv ***
`timescale 1ns/100ps
`include "uarx_consts.svh"
// Behaviour
// - Sample at 16x baud normally, 8x with double speed select.
// - Idle falling edge starts detection; first low sample is sample one.
// - Start qualified by samples 8,9,10 normal or 4,5,6 double speed.
// - Two or more high qualification samples reject start as noise.
// - Bit phase realigns to every valid start bit.
// - Per-bit counter of 16 or 8 states numbers each sample.
// - Data and parity bits decided by majority of three centre samples.
// - Recover up to first stop bit; further stop bits ignored.
// - First stop bit by majority; zero sets stop-bit error flag.
// - Normal mode accepts new start right after last stop vote sample.
// - With filter enabled, non-address frames are dropped from buffer.
// - Filter enable affects only the receive path, not transmitter.
// - Frame type is first stop bit for 5-8 bits, ninth bit for nine.
// - Type one means address frame, zero means data frame.
// - Filter cleared accepts data; filter set drops every data frame, also after an address.
// - Overrun when buffer full, holding stage full, new start seen.
// - Disabling receiver aborts reception and flushes buffer at once.
// - Address frames set receive complete as usual in filter mode.
module uarx_rx
    import uarx_pkg::*;
#(
    parameter int DIV_W = 16
) (
    input  wire logic                 clk,          // 40 MHz clock
    input  wire logic                 resetn,       // Async reset, low
    input  wire logic                 rx_line,      // Serial input
    input  wire logic                 rx_enable,    // Receiver enable
    input  wire logic                 double_speed_select, // 8x sampling
    input  wire logic                 multiprocessor_filter_enable, // Filter
    input  wire logic [2:0]           char_size,    // 0..3: 5..8, 4: 9
    input  wire logic                 parity_en,    // Parity present
    input  wire logic                 parity_odd,   // Odd parity
    input  wire logic [DIV_W-1:0]     baud_divider, // Sample period - 1
    input  wire logic                 rd_strobe,    // Read takes a char
    output logic [7:0]                data_buffer_port, // Oldest char
    output logic                      received_ninth_bit, // Ninth bit
    output logic                      stop_bit_error_flag, // Frame error
    output logic                      parity_error_flag,   // Parity error
    output logic                      overrun_flag, // Data lost
    output logic                      rx_complete   // Unread data
);
    import uarx_pkg::*;

    initial begin
        if (DIV_W < 1 || DIV_W > 16) $error("uarx_rx: bad DIV_W");
    end

    //------------------------------------------------------------
    // Sample tick and line synchroniser
    //------------------------------------------------------------
    logic [DIV_W-1:0] div_r;
    logic             tick_r;
    logic             sync1_r;
    logic             sync2_r;
    logic             prev_r;

    // Divider gives one-cycle sample enable
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_r  <= '0;
            tick_r <= 1'b0;
        end else if (!rx_enable || div_r == '0) begin
            div_r  <= baud_divider;
            tick_r <= rx_enable;
        end else begin
            div_r  <= div_r - 1'b1;
            tick_r <= 1'b0;
        end
    end

    // Two-stage synchroniser; only sync2 is looked at
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            prev_r  <= 1'b1;
        end else begin
            sync1_r <= rx_line;
            sync2_r <= sync1_r;
            if (tick_r) prev_r <= sync2_r;
        end
    end

    //------------------------------------------------------------
    // Recovery state machine
    //------------------------------------------------------------
    uarx_state_type state_r;
    uarx_state_type state_nxt;
    logic [4:0]     samp_r;      // Sample number within bit
    logic [3:0]     bitn_r;      // Data bits taken
    logic [2:0]     vote_r;      // Centre samples
    logic [8:0]     shift_r;
    logic           par_bit_r;
    logic           hold_r;      // Char waiting in holding stage
    uarx_char_type  hold_char_r;
    wire [4:0] spb     = double_speed_select ? `UARX_SPB_DBL
                                             : `UARX_SPB_NORM;
    wire [4:0] ctr     = double_speed_select ? `UARX_CTR_DBL
                                             : `UARX_CTR_NORM;
    wire [4:0] vote_hi = ctr + 5'd2;
    wire       in_vote = (samp_r >= ctr) && (samp_r <= vote_hi);
    wire       vote_done = tick_r && (samp_r == vote_hi);
    wire       bit_end = tick_r && (samp_r == spb);
    // Majority of the three centre samples
    wire [2:0] vote_all = {vote_r[1:0], sync2_r};
    wire       majority = (vote_all[0] & vote_all[1]) |
                          (vote_all[0] & vote_all[2]) |
                          (vote_all[1] & vote_all[2]);
    wire [3:0] nbits   = (char_size == `UARX_CSZ_NINE) ? 4'd9
                                     : {1'b0, char_size} + 4'd5;
    wire       fall    = tick_r && prev_r && !sync2_r;
    // Stop bit ends after its last vote sample in normal mode;
    // double speed waits for the end of the bit
    wire       stop_done = (state_r == UARX_STOP) &&
                           (double_speed_select ? bit_end
                                                : vote_done);
    wire       start_ok  = (state_r == UARX_START) && vote_done &&
                           !majority;
    wire       start_bad = (state_r == UARX_START) && vote_done &&
                           majority;

    // Next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            UARX_IDLE:  if (fall) state_nxt = UARX_START;
            UARX_START: if (start_bad) state_nxt = UARX_IDLE;
                        else if (start_ok) state_nxt = UARX_DATA;
            UARX_DATA:  if (bit_end && bitn_r == nbits)
                            state_nxt = parity_en ? UARX_PAR : UARX_STOP;
            UARX_PAR:   if (bit_end) state_nxt = UARX_STOP;
            UARX_STOP:  if (stop_done) state_nxt = UARX_IDLE;
            default:    state_nxt = UARX_IDLE;
        endcase
    end

    // Frame finished: assemble status
    wire [8:0] data_al   = shift_r >> (4'd9 - nbits);
    // Low shift bits still hold the last frame, so only the
    // aligned data bits enter the parity sum
    wire       par_calc  = ^data_al ^ parity_odd;
    wire       stop_bit  = majority;
    wire       frm_type  = (char_size == `UARX_CSZ_NINE) ? data_al[8]
                                                         : stop_bit;
    wire       frm_addr  = frm_type;
    wire       frm_end   = (state_r == UARX_STOP) && vote_done;
    // Filter only gates entry to the buffer
    wire       frm_keep  = !multiprocessor_filter_enable ||
                           frm_addr;

    uarx_char_type buf_in;
    uarx_char_type buf_out;
    logic          buf_ready;
    logic          buf_valid;
    wire           flush = !rx_enable;

    assign buf_in = hold_char_r;

    uarx_buf #(
        .WIDTH ($bits(uarx_char_type))
    ) u_buf (
        .clk       (clk),
        .resetn    (resetn),
        .flush     (flush),
        .in_data   (buf_in),
        .in_valid  (hold_r),
        .in_ready  (buf_ready),
        .out_data  (buf_out),
        .out_valid (buf_valid),
        .out_ready (rd_strobe)
    );

    wire start_seen = (state_r == UARX_IDLE) && fall;
    wire ovr_set = start_seen && hold_r && !buf_ready;
    wire moved   = hold_r && buf_ready;

    // State, sample counter and votes; counter moves on tick only
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= UARX_IDLE;
            samp_r  <= 5'd0;
            bitn_r  <= 4'd0;
            vote_r  <= 3'd0;
        end else if (!rx_enable) begin
            state_r <= UARX_IDLE;
            samp_r  <= 5'd0;
            bitn_r  <= 4'd0;
        end else begin
            state_r <= state_nxt;
            if (start_seen) begin
                samp_r <= 5'd2;   // the falling sample was one
                bitn_r <= 4'd0;
            end else if (tick_r) begin
                // Start bit runs on to its own end, so every later
                // bit is voted at its true centre samples
                samp_r <= (samp_r == spb) ? 5'd1 : samp_r + 5'd1;
                if (in_vote) vote_r <= vote_all;
                if (bit_end && state_r == UARX_DATA)
                    bitn_r <= bitn_r + 4'd1;
            end
        end
    end

    // Shift register and holding stage
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shift_r     <= 9'h000;
            par_bit_r   <= 1'b0;
            hold_r      <= 1'b0;
            hold_char_r <= '0;
        end else if (!rx_enable) begin
            hold_r <= 1'b0;
        end else begin
            if (vote_done && state_r == UARX_DATA)
                shift_r <= {majority, shift_r[8:1]};
            if (vote_done && state_r == UARX_PAR)
                par_bit_r <= majority;
            if (moved) hold_r <= 1'b0;
            if (frm_end && frm_keep) begin
                hold_r               <= 1'b1;
                hold_char_r.data     <= data_al;
                hold_char_r.stop_err <= !stop_bit;
                hold_char_r.par_err  <= parity_en &&
                                        (par_calc != par_bit_r);
            end
        end
    end

    // Overrun flag: set wins over the clear by a successful move
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) overrun_flag <= 1'b0;
        else if (!rx_enable) overrun_flag <= 1'b0;
        else if (ovr_set) overrun_flag <= 1'b1;
        else if (moved) overrun_flag <= 1'b0;
    end

    // Outputs show the oldest buffered character, zero when empty
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            data_buffer_port    <= 8'h00;
            received_ninth_bit  <= 1'b0;
            stop_bit_error_flag <= 1'b0;
            parity_error_flag   <= 1'b0;
        end else begin
            data_buffer_port    <= buf_valid ? buf_out.data[7:0] : 8'h00;
            received_ninth_bit  <= buf_valid && buf_out.data[8];
            stop_bit_error_flag <= buf_valid && buf_out.stop_err;
            parity_error_flag   <= buf_valid && buf_out.par_err;
        end
    end

    assign rx_complete = buf_valid;

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    sequence s_start_rej;
        (state_r == UARX_START) && start_bad;
    endsequence

    // Start qualified while enabled
    sequence s_start_take;
        rx_enable && (state_r == UARX_START) && start_ok;
    endsequence

    // Last vote sample of the first stop bit while enabled
    sequence s_stop_vote;
        rx_enable && (state_r == UARX_STOP) && vote_done;
    endsequence

    AST_NOISE_REJ: assert property (@(posedge clk) disable iff (!resetn)
        s_start_rej |=> state_r == UARX_IDLE)
        else $error("noisy start not rejected");
    AST_START_SEQ: assert property (@(posedge clk) disable iff (!resetn)
        (rx_enable && start_seen) |=> state_r == UARX_START &&
        samp_r == 5'd2)
        else $error("start edge not taken");
    AST_FLUSH: assert property (@(posedge clk) disable iff (!resetn)
        !rx_enable |=> !rx_complete && state_r == UARX_IDLE)
        else $error("disable did not flush");
    AST_OVR: assert property (@(posedge clk) disable iff (!resetn)
        (rx_enable && ovr_set) |=> overrun_flag)
        else $error("overrun not flagged");
    AST_FILTER: assert property (@(posedge clk) disable iff (!resetn)
        (rx_enable && frm_end && multiprocessor_filter_enable &&
         !frm_type && !hold_r) |=> !hold_r)
        else $error("data frame not filtered");
    AST_ADDR_KEEP: assert property (@(posedge clk) disable iff (!resetn)
        (rx_enable && frm_end && frm_type) |=> hold_r)
        else $error("address frame lost");
    AST_SAMP_RANGE: assert property (@(posedge clk) disable iff (!resetn)
        state_r != UARX_IDLE |-> samp_r <= spb)
        else $error("sample counter past bit length");
    AST_TICK_ONLY: assert property (@(posedge clk) disable iff (!resetn)
        (!tick_r && !start_seen && rx_enable && $past(rx_enable))
        |=> $stable(samp_r))
        else $error("counter moved without tick");
    AST_STOP_ERR: assert property (@(posedge clk) disable iff (!resetn)
        (rx_enable && frm_end && frm_keep && !majority)
        |=> hold_char_r.stop_err)
        else $error("stop error not recorded");

    // Phase must run on from the start samples, not restart
    AST_ALIGN: assert property (@(posedge clk) disable iff (!resetn)
        s_start_take |=> state_r == UARX_DATA &&
        samp_r == $past(vote_hi) + 5'd1)
        else $error("bit phase not carried from start");
    AST_DATA_VOTE: assert property (@(posedge clk) disable iff (!resetn)
        (rx_enable && vote_done && state_r == UARX_DATA)
        |=> shift_r[8] == $past(majority))
        else $error("data bit not taken by majority");
    // Early restart only in normal mode; double speed waits
    AST_STOP_NORM: assert property (@(posedge clk) disable iff (!resetn)
        s_stop_vote ##0 !double_speed_select |=> state_r == UARX_IDLE)
        else $error("normal mode stop not ended at vote");
    AST_STOP_DBL: assert property (@(posedge clk) disable iff (!resetn)
        s_stop_vote ##0 double_speed_select |=> state_r == UARX_STOP)
        else $error("double speed stop ended too early");
    AST_ONE_STOP: assert property (@(posedge clk) disable iff (!resetn)
        s_stop_vote |=> state_r inside {UARX_IDLE, UARX_STOP})
        else $error("recovery ran past first stop bit");
    AST_OVR_CLR: assert property (@(posedge clk) disable iff (!resetn)
        (rx_enable && moved && !ovr_set) |=> !overrun_flag)
        else $error("overrun not cleared by move");
    AST_SYNC: assert property (@(posedge clk) disable iff (!resetn)
        rx_enable |=> sync2_r == $past(sync1_r))
        else $error("line synchroniser skipped a stage");
endmodule

// *** tb/uarx_tx_model.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------
// Remote serial transmitter
// ------------------------------------------------------------
// Bit times are counted in system clocks, so the bench can run
// it slightly fast or slow against the receiver's sample clock.
module uarx_tx_model (
    input  wire logic clk,  // Time base
    output logic      line  // Shared serial line, idle high
);
    initial line = 1'b1;

    // Hold one level for n clocks; called on a falling edge
    task automatic drive(input logic v, input int n);
        line <= v;
        repeat (n) @(negedge clk);
    endtask

    // Start, data LSB first, optional parity, one stop of sc clocks
    task automatic send(input logic [8:0] d, input int nb, input logic pen,
                        input logic pbit, input logic stp, input int bc,
                        input int sc);
        int i;
        @(negedge clk);
        drive(1'b0, bc);
        for (i = 0; i < nb; i++) begin
            drive(d[i], bc);
        end
        if (pen) begin
            drive(pbit, bc);
        end
        drive(stp, sc);
        line <= 1'b1;
    endtask
endmodule

// *** tb/uarx_rx_tb_top.sv ***
`timescale 1ns/100ps
module uarx_rx_tb_top;
    import uarx_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        clk;
    logic        resetn;
    logic        rx_line;
    logic        rx_enable;
    logic        dss;
    logic        mpf;
    logic [2:0]  csz;
    logic        pen;
    logic        podd;
    logic [15:0] bdiv;
    logic        rd_strobe;
    logic [7:0]  dout;
    logic        nin;
    logic        fe;
    logic        pe;
    logic        ovr;
    logic        rxc;
    int          failures;
    int          check_count;
    int          cyc = 0;
    logic [31:0] seed;

    uarx_tx_model i_tx (.clk(clk), .line(rx_line));

    uarx_rx i_dut (
        .clk                          (clk),
        .resetn                       (resetn),
        .rx_line                      (rx_line),
        .rx_enable                    (rx_enable),
        .double_speed_select          (dss),
        .multiprocessor_filter_enable (mpf),
        .char_size                    (csz),
        .parity_en                    (pen),
        .parity_odd                   (podd),
        .baud_divider                 (bdiv),
        .rd_strobe                    (rd_strobe),
        .data_buffer_port             (dout),
        .received_ninth_bit           (nin),
        .stop_bit_error_flag          (fe),
        .parity_error_flag            (pe),
        .overrun_flag                 (ovr),
        .rx_complete                  (rxc)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Cut a hang short; the planned run stays well under this
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            failures = failures + 1;
            end_of_test();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [8:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[8:0];
    endfunction

    function automatic int nbits();
        return (csz == 3'h4) ? 9 : int'(csz) + 5;
    endfunction

    function automatic logic [8:0] msk(input logic [8:0] d, input int nb);
        return d & ((9'h001 << nb) - 9'h001);
    endfunction

    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Send under the current size and parity; bad flips the parity bit
    task automatic frame(input logic [8:0] d, input logic bad,
                         input logic stp, input int bc, input int sc);
        logic pbit;
        pbit = (^msk(d, nbits())) ^ podd ^ bad;
        i_tx.send(d, nbits(), pen, pbit, stp, bc, sc);
    endtask

    // Check the oldest character, then pop it; flags lag by a clock
    task automatic rd(input logic [8:0] d, input logic fx, input logic px);
        repeat (4) @(negedge clk);
        chk({rxc, fe, pe, nin, dout}, {1'b1, fx, px, msk(d, nbits())});
        rd_strobe <= 1'b1;
        @(negedge clk);
        rd_strobe <= 1'b0;
        @(negedge clk);
    endtask

    task automatic empty_chk();
        repeat (4) @(negedge clk);
        chk({rxc, fe, pe, nin, dout}, 12'h000);
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int         k;
        logic [8:0] d;
        logic [8:0] q [4];
        resetn      = 1'b0;
        rx_enable   = 1'b1;
        dss         = 1'b0;
        mpf         = 1'b0;
        csz         = 3'h3;
        pen         = 1'b0;
        podd        = 1'b0;
        bdiv        = 16'h0003;
        rd_strobe   = 1'b0;
        failures    = 0;
        check_count = 0;
        seed        = 32'h0000fe61;
        repeat (10) @(negedge clk);
        resetn = 1'b1;
        empty_chk();
        chk({11'h000, ovr}, 12'h000);
        // Every size, random parity mode, transmitter fast, exact, slow
        for (k = 0; k < 15; k++) begin
            csz  = 3'(k % 5);
            d    = xs();
            pen  = d[0];
            podd = d[1];
            d    = xs();
            frame(d, 1'b0, 1'b1, 63 + k % 3, 64);
            rd(d, 1'b0, 1'b0);
        end
        // Corrupt parity, then a low stop bit, then two stop bits
        csz  = 3'h3;
        pen  = 1'b1;
        podd = 1'b1;
        d    = xs();
        frame(d, 1'b1, 1'b1, 64, 64);
        rd(d, 1'b0, 1'b1);
        pen = 1'b0;
        frame(d, 1'b0, 1'b0, 64, 64);
        rd(d, 1'b1, 1'b0);
        frame(d, 1'b0, 1'b1, 64, 128);
        rd(d, 1'b0, 1'b0);
        // A short low spike must not start a frame
        i_tx.drive(1'b0, 16);
        i_tx.drive(1'b1, 64);
        empty_chk();
        // Next start right after the stop vote samples
        q[0] = xs();
        q[1] = xs();
        frame(q[0], 1'b0, 1'b1, 64, 48);
        frame(q[1], 1'b0, 1'b1, 64, 64);
        rd(q[0], 1'b0, 1'b0);
        rd(q[1], 1'b0, 1'b0);
        // Double speed, back to back with full stop bits
        dss = 1'b1;
        q[0] = xs();
        q[1] = xs();
        frame(q[0], 1'b0, 1'b1, 32, 32);
        frame(q[1], 1'b0, 1'b1, 32, 32);
        rd(q[0], 1'b0, 1'b0);
        rd(q[1], 1'b0, 1'b0);
        // Fill buffer and hold stage, then one more: third is lost
        dss = 1'b0;
        for (k = 0; k < 4; k++) begin
            q[k] = xs();
            frame(q[k], 1'b0, 1'b1, 64, 64);
        end
        chk({11'h000, ovr}, 12'h001);
        rd(q[0], 1'b0, 1'b0);
        chk({11'h000, ovr}, 12'h000);
        rd(q[1], 1'b0, 1'b0);
        rd(q[3], 1'b0, 1'b0);
        empty_chk();
        // Filter: nine-bit type bit, then stop bit as type
        mpf = 1'b1;
        csz = 3'h4;
        frame(xs() & 9'h0ff, 1'b0, 1'b1, 64, 64);
        empty_chk();
        d = xs() | 9'h100;
        frame(d, 1'b0, 1'b1, 64, 64);
        rd(d, 1'b0, 1'b0);
        frame(xs() & 9'h0ff, 1'b0, 1'b1, 64, 64);
        empty_chk();
        csz = 3'h2;
        d   = xs();
        frame(d, 1'b0, 1'b0, 64, 64);
        empty_chk();
        frame(d, 1'b0, 1'b1, 64, 64);
        rd(d, 1'b0, 1'b0);
        mpf = 1'b0;
        csz = 3'h4;
        d   = xs() & 9'h0ff;
        frame(d, 1'b0, 1'b1, 64, 64);
        rd(d, 1'b0, 1'b0);
        // Disable flushes stored data and ignores the line
        frame(xs(), 1'b0, 1'b1, 64, 64);
        rx_enable = 1'b0;
        empty_chk();
        frame(xs(), 1'b0, 1'b1, 64, 64);
        empty_chk();
        rx_enable = 1'b1;
        end_of_test();
    end
endmodule
